// file: amotr_pkg.sv
/*
  package for the alert mask and overheat timer register group: offsets,
  field positions, reset values and timing counts.
  assumes a 40 MHz mclk and an apb master with 32-bit data.
*/
package amotr_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] AMOTR_IDX_MASK_CH = 8'h74;
  localparam logic [7:0] AMOTR_IDX_MASK_FLT = 8'h75;
  localparam logic [7:0] AMOTR_IDX_VOLT_LOW = 8'h76;
  localparam logic [7:0] AMOTR_IDX_TEMP_LOW = 8'h77;
  localparam logic [7:0] AMOTR_IDX_CFG3 = 8'h78;
  localparam logic [7:0] AMOTR_IDX_OVH_STAT = 8'h79;
  // register indices of our own choosing for limit and lock
  localparam logic [7:0] AMOTR_IDX_OVH_LIMIT = 8'h7a;
  localparam logic [7:0] AMOTR_IDX_LOCK = 8'h80;
  // reset values
  localparam logic [7:0] AMOTR_RST_MASK = 8'h00;
  localparam logic [7:0] AMOTR_RST_CFG3 = 8'h00;
  localparam logic [7:0] AMOTR_RST_STAT = 8'h00;
  // field positions
  localparam int AMOTR_MCH_VOLT = 0;
  localparam int AMOTR_MCH_SUPPLY = 2;
  localparam int AMOTR_MCH_REMOTE_A = 4;
  localparam int AMOTR_MCH_LOCAL = 5;
  localparam int AMOTR_MCH_REMOTE_B = 6;
  localparam int AMOTR_MCH_ANY_S2 = 7;
  localparam int AMOTR_MFL_OVT = 1;
  localparam int AMOTR_MFL_FIRST_FAN_FAULT_MASK = 2;
  localparam int AMOTR_MFL_FAN4 = 5;
  localparam int AMOTR_MFL_DIODE_A = 6;
  localparam int AMOTR_MFL_DIODE_B = 7;
  localparam int AMOTR_CFG_ALERT = 0;
  localparam int AMOTR_CFG_OVH_ON = 1;
  localparam int AMOTR_CFG_FULL_SPEED_ON_OVERHEAT = 2;
  localparam int AMOTR_CFG_FAST = 3;
  localparam int AMOTR_CFG_CONT0 = 4;
  // timing: step is 22.76 ms, first report after two steps (45.52 ms)
  localparam real AMOTR_CLK_MHZ = 40.0;
  localparam real AMOTR_STEP_MS = 22.76;
  localparam int AMOTR_STEP_CYC = int'(AMOTR_STEP_MS * AMOTR_CLK_MHZ * 1000.0 - 0.5);
  localparam real AMOTR_SLOW_MS = 1000.0;
  localparam real AMOTR_FAST_MS = 250.0;
  localparam int AMOTR_SLOW_CYC = int'(AMOTR_SLOW_MS * AMOTR_CLK_MHZ * 1000.0 - 0.5);
  localparam int AMOTR_FAST_CYC = int'(AMOTR_FAST_MS * AMOTR_CLK_MHZ * 1000.0 - 0.5);
endpackage : amotr_pkg

// file: amotr_regs.sv
/*
  alert mask and overheat timer register group with an apb slave.
  assumes inputs synchronous to mclk; readings and status come from the
  conversion engine and limit comparators outside this block.
  the host bus is a zero-wait apb slave: pready is tied high and read data
  is registered, so it shows on prdata from the edge that ends the access.
  the alert pin is open-drain: the block only ever pulls it low.
  the overheat pin is active low and taken as already synchronous.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module amotr_regs
  import amotr_pkg::*;
#(
  parameter int STEP_CYC = AMOTR_STEP_CYC, // cycles per 22.76 ms step
  parameter int SLOW_CYC = AMOTR_SLOW_CYC, // cycles per 1 s sample
  parameter int FAST_CYC = AMOTR_FAST_CYC  // cycles per 250 ms sample
) (
  input wire logic mclk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // live 10-bit readings from the converter
  input wire logic [9:0] volt_reading,
  input wire logic [9:0] supply_reading,
  input wire logic [9:0] remote_a_reading,
  input wire logic [9:0] local_reading,
  input wire logic [9:0] remote_b_reading,
  // frozen high bytes for the result registers outside
  output logic [7:0] volt_high,
  output logic [7:0] supply_high,
  output logic [7:0] remote_a_high,
  output logic [7:0] local_high,
  output logic [7:0] remote_b_high,
  // a read of a high-byte result register, one pulse per byte
  input wire logic [4:0] high_byte_read,
  // status conditions from the comparators
  input wire logic [4:0] channel_limit, // volt, supply, remote a, local, remote b
  input wire logic status2_limit_any,
  input wire logic [3:0] fan_fault,
  input wire logic [1:0] diode_fault,
  input wire logic fourth_is_overheat, // fourth speed input used as overheat
  input wire logic overheat_pin_n, // overheat input, active low
  input wire logic config_lock,
  // outputs
  output logic alert_pin_o,
  output logic alert_pin_oe,
  output logic pwm2_is_alert,
  output logic fans_full_speed,
  output logic overheat_timer_event,
  output logic [3:0] speed_sample_strobe,
  output logic [3:0] speed_continuous
);
  // registered state
  // all registers below but samp_cnt are written only by the single always_ff
  // further down; their next_ values are worked out in one always_comb so that a bus
  // access, a freeze release and a timer step in one cycle are resolved in
  // one place and in a fixed order (timer first, then reads, then writes).
  // step_cnt and samp_cnt are a full 32 bits so that the real 40 MHz counts
  // fit; the bench shortens them through the parameters.
  logic [7:0] mask_ch, next_mask_ch;
  logic [7:0] mask_flt, next_mask_flt;
  logic [7:0] cfg3, next_cfg3;
  logic [7:0] ovh_limit, next_ovh_limit;
  logic [7:0] volt_low, next_volt_low;
  logic [7:0] temp_low, next_temp_low;
  logic [7:0] stat, next_stat;
  logic [39:0] highs, next_highs; // five high bytes
  logic [4:0] pend_high, next_pend_high; // high bytes still owed a read
  logic [31:0] step_cnt, next_step_cnt;
  logic [8:0] steps, next_steps; // whole steps of assertion
  logic [31:0] samp_cnt, next_samp_cnt;
  logic [31:0] rdata, next_rdata;
  logic ovh_evt, next_ovh_evt;

  // apb decode: zero-wait access, unmapped addresses error
  // the word index is taken from paddr[9:2]; any address with the low two
  // bits set or above the window is refused with pslverr so that software
  // sees a misaligned or stray access instead of silently reading zero.
  // only the access phase (psel and penable) counts: a setup cycle alone
  // never changes state, which keeps a master that idles in setup harmless.
  logic acc, wr, rd, mapped;
  logic [7:0] idx;
  logic overheat;
  assign idx = paddr[9:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign overheat = !overheat_pin_n && cfg3[AMOTR_CFG_OVH_ON];
  always_comb begin
    mapped = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
      ((idx >= AMOTR_IDX_MASK_CH && idx <= AMOTR_IDX_OVH_LIMIT) || idx == AMOTR_IDX_LOCK);
  end
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = rdata;

  // low-bit freeze bookkeeping
  // one pending bit per high byte: a low-bits read sets the bits of the
  // readings it covers, a pulse on high_byte_read clears its own bit.
  // while any bit is pending, all low and high copies hold still, so that a
  // 10-bit value is always read back as one coherent pair.
  // limitation: a host that never reads the high bytes freezes the readings
  // for good; that is the price of a coherent pair without extra buffering.
  logic frozen;
  assign frozen = |pend_high;

  // next-state logic for registers and timers
  // defaults hold every register but pend_high, which drops the bits high_byte_read names; the sections below only override what
  // changes. the event flag defaults low so it is a level that follows the
  // timer each cycle rather than a sticky bit.
  // if a set and a clear meet in one cycle, the later assignment in this
  // process wins, and the order is chosen so that a set always wins.
  always_comb begin
    next_mask_ch = mask_ch;
    next_mask_flt = mask_flt;
    next_cfg3 = cfg3;
    next_ovh_limit = ovh_limit;
    next_volt_low = volt_low;
    next_temp_low = temp_low;
    next_highs = highs;
    next_pend_high = pend_high & ~high_byte_read; // high byte read releases it
    next_stat = stat;
    next_step_cnt = step_cnt;
    next_steps = steps;
    next_ovh_evt = 1'b0;
    next_rdata = rdata;
    // readings track the converter unless frozen
    if (!frozen) begin
      next_volt_low = {2'h0, supply_reading[1:0], 2'h0, volt_reading[1:0]};
      next_temp_low = {remote_b_reading[1:0], local_reading[1:0],
        remote_a_reading[1:0], 2'h0};
      next_highs = {remote_b_reading[9:2], local_reading[9:2], remote_a_reading[9:2],
        supply_reading[9:2], volt_reading[9:2]};
    end
    // overheat duration timer
    // step_cnt divides the clock into 22.76 ms steps and steps counts whole
    // steps of one unbroken assertion; both return to zero the moment the
    // input is released or monitoring is off.
    // steps is one bit wider than the reported count so that saturation can
    // be seen without a separate flag.
    // the status register only starts to follow the count after two whole
    // steps; before that it holds just the assertion-seen bit.
    // the event compares against the limit every cycle while asserted.
    if (overheat) begin
      if (steps == 9'h000 && step_cnt == 32'h0) begin
        next_stat[0] = 1'b1; // assertion seen
      end
      if (step_cnt >= 32'(STEP_CYC - 1)) begin
        next_step_cnt = 32'h0;
        if (steps != 9'h1ff) begin
          next_steps = steps + 9'h001;
        end
      end else begin
        next_step_cnt = step_cnt + 32'h1;
      end
      // report count once two steps are complete, saturating at 0xff
      if (steps >= 9'h002) begin
        next_stat = (steps > 9'h0ff) ? 8'hff : steps[7:0];
      end
      // limit exceeded; limit of zero fires at once
      if ({1'b0, ovh_limit} < steps || ovh_limit == 8'h00) begin
        next_ovh_evt = 1'b1;
      end
    end else begin
      next_step_cnt = 32'h0;
      next_steps = 9'h000;
    end
    // reads
    // read data is loaded at the access edge and then held, so a master
    // that samples prdata one cycle later always sees a stable value.
    // reads with side effects (freeze, clear on read) act only here, once
    // per access, never during the setup cycle.
    if (rd) begin
      case (idx)
        AMOTR_IDX_MASK_CH: next_rdata = {24'h0, mask_ch};
        AMOTR_IDX_MASK_FLT: next_rdata = {24'h0, mask_flt};
        AMOTR_IDX_VOLT_LOW: begin
          next_rdata = {24'h0, volt_low};
          next_pend_high = next_pend_high | 5'h03; // freeze until highs read
        end
        AMOTR_IDX_TEMP_LOW: begin
          next_rdata = {24'h0, temp_low};
          next_pend_high = next_pend_high | 5'h1c;
        end
        AMOTR_IDX_CFG3: next_rdata = {24'h0, cfg3};
        AMOTR_IDX_OVH_STAT: begin
          next_rdata = {24'h0, stat};
          // read clears; a fresh assertion in the same cycle still wins
          if (!(overheat && steps == 9'h000 && step_cnt == 32'h0)) begin
            next_stat = overheat && steps >= 9'h002 ? next_stat : AMOTR_RST_STAT;
          end
        end
        AMOTR_IDX_OVH_LIMIT: next_rdata = {24'h0, ovh_limit};
        AMOTR_IDX_LOCK: next_rdata = {31'h0, config_lock};
        default: next_rdata = 32'h0;
      endcase
    end
    // writes
    // writes come after reads so a write can never be undone by a read
    // side effect in the same cycle (they cannot overlap on apb anyway).
    // the low-bits and status registers have no write branch: the hardware
    // owns them and a stray write must not disturb a frozen pair.
    if (wr) begin
      case (idx)
        AMOTR_IDX_MASK_CH: next_mask_ch = pwdata[7:0];
        AMOTR_IDX_MASK_FLT: begin
          next_mask_flt = {pwdata[7:2], mask_flt[AMOTR_MFL_OVT], pwdata[0]};
        end
        AMOTR_IDX_CFG3: begin
          if (!config_lock) begin
            next_cfg3 = pwdata[7:0];
          end
        end
        AMOTR_IDX_OVH_LIMIT: next_ovh_limit = pwdata[7:0];
        default: next_cfg3 = next_cfg3; // read-only or unmapped: ignored
      endcase
    end
  end

  // register update
  // plain flops only: synchronous reset to the documented defaults, and
  // otherwise a copy of the next_ values. keeping the logic out of this
  // process means reset can only ever load constants.
  // the limit register resets to zero, which fires the event as soon as overheat is seen.
  always_ff @(posedge mclk) begin
    if (rst) begin
      mask_ch <= AMOTR_RST_MASK;
      mask_flt <= AMOTR_RST_MASK;
      cfg3 <= AMOTR_RST_CFG3;
      ovh_limit <= 8'h00;
      volt_low <= 8'h00;
      temp_low <= 8'h00;
      highs <= 40'h0;
      pend_high <= 5'h00;
      stat <= AMOTR_RST_STAT;
      step_cnt <= 32'h0;
      steps <= 9'h000;
      rdata <= 32'h0;
      ovh_evt <= 1'b0;
    end else begin
      mask_ch <= next_mask_ch;
      mask_flt <= next_mask_flt;
      cfg3 <= next_cfg3;
      ovh_limit <= next_ovh_limit;
      volt_low <= next_volt_low;
      temp_low <= next_temp_low;
      highs <= next_highs;
      pend_high <= next_pend_high;
      stat <= next_stat;
      step_cnt <= next_step_cnt;
      steps <= next_steps;
      rdata <= next_rdata;
      ovh_evt <= next_ovh_evt;
    end
  end

  // high bytes go out to the result registers, which live outside this
  // block; they come straight from flops so the host never sees a byte
  // change part way through a read.
  assign volt_high = highs[7:0];
  assign supply_high = highs[15:8];
  assign remote_a_high = highs[23:16];
  assign local_high = highs[31:24];
  assign remote_b_high = highs[39:32];
  assign overheat_timer_event = ovh_evt;

  // alert combine: each unmasked condition pulls the pin low
  // the conditions are levels from the comparators, so the alert follows
  // them directly with no latching here; clearing a condition or setting
  // its mask bit releases the pin in the same cycle.
  // the fourth fan fault and the overheat event share one mask bit; which
  // one is watched depends on how the fourth speed input is used.
  logic any_alert;
  always_comb begin
    any_alert = (channel_limit[0] && !mask_ch[AMOTR_MCH_VOLT]) ||
      (channel_limit[1] && !mask_ch[AMOTR_MCH_SUPPLY]) ||
      (channel_limit[2] && !mask_ch[AMOTR_MCH_REMOTE_A]) ||
      (channel_limit[3] && !mask_ch[AMOTR_MCH_LOCAL]) ||
      (channel_limit[4] && !mask_ch[AMOTR_MCH_REMOTE_B]) ||
      (status2_limit_any && !mask_ch[AMOTR_MCH_ANY_S2]) ||
      (|(fan_fault[2:0] & ~mask_flt[AMOTR_MFL_FAN4-1:AMOTR_MFL_FIRST_FAN_FAULT_MASK])) ||
      (!fourth_is_overheat && fan_fault[3] && !mask_flt[AMOTR_MFL_FAN4]) ||
      (fourth_is_overheat && ovh_evt && !mask_flt[AMOTR_MFL_FAN4]) ||
      (diode_fault[0] && !mask_flt[AMOTR_MFL_DIODE_A]) ||
      (diode_fault[1] && !mask_flt[AMOTR_MFL_DIODE_B]);
  end
  // open-drain: drive low only, release otherwise
  // the data side is tied low and only the enable moves, so the pin can
  // never be driven high against another device on the shared line.
  // while the pin serves as pwm output the enable stays low.
  assign alert_pin_o = 1'b0;
  assign alert_pin_oe = cfg3[AMOTR_CFG_ALERT] && any_alert;
  assign pwm2_is_alert = cfg3[AMOTR_CFG_ALERT];
  // full_speed_on_overheat uses the raw pin so a full_speed_on_overheat works even without monitoring
  assign fans_full_speed = cfg3[AMOTR_CFG_FULL_SPEED_ON_OVERHEAT] && !overheat_pin_n;

  // speed sampling tick: 1 s or 250 ms
  // one free-running counter serves all four fans; a change of rate takes
  // effect at once, which can stretch or shorten one period by up to a
  // full slow period. that is accepted to save a second counter.
  // the tick is high for exactly one cycle per period.
  logic samp_tick;
  always_comb begin
    samp_tick = samp_cnt >= (cfg3[AMOTR_CFG_FAST] ? 32'(FAST_CYC - 1) : 32'(SLOW_CYC - 1));
    next_samp_cnt = samp_tick ? 32'h0 : samp_cnt + 32'h1;
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      samp_cnt <= 32'h0;
    end else begin
      samp_cnt <= next_samp_cnt;
    end
  end
  // per fan: continuous mode strobes each cycle, else on the tick
  // the strobe is a request to the speed counters outside; continuous mode
  // simply holds it high, so those counters restart without a gap.
  // all four fans share the one tick, so their measurements line up.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fan
      assign speed_continuous[g] = cfg3[AMOTR_CFG_CONT0 + g];
      assign speed_sample_strobe[g] = cfg3[AMOTR_CFG_CONT0 + g] || samp_tick;
    end
  endgenerate
endmodule : amotr_regs
`default_nettype wire

// file: amotr_regs_monitor.sv
/*
  port checker for the alert mask and overheat timer registers.
  assumes the port names of amotr_regs; attached by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module amotr_regs_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic config_lock,
  input wire logic overheat_pin_n,
  input wire logic pwm2_is_alert,
  input wire logic alert_pin_o,
  input wire logic alert_pin_oe,
  input wire logic fans_full_speed,
  input wire logic overheat_timer_event,
  input wire logic [3:0] speed_sample_strobe,
  input wire logic [3:0] speed_continuous
);
  // one clock domain, so clock and reset are given once
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_access_ready: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_mapped_quiet: assert property (psel && penable && paddr == 12'h1d0 |-> !pslverr)
    else $error("error on mapped address");
  a_read_upper: assert property ($past(psel && penable && !pwrite) |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_alert_low: assert property (alert_pin_oe |-> !alert_pin_o)
    else $error("alert driven high");
  a_alert_gated: assert property (!pwm2_is_alert |-> !alert_pin_oe)
    else $error("alert driven while pin is pwm");
  a_full_speed_on_overheat_pin: assert property (fans_full_speed |-> !overheat_pin_n)
    else $error("full speed without overheat");
  a_cont_strobe: assert property (&(speed_sample_strobe | ~speed_continuous))
    else $error("continuous fan not sampled");
  a_tick_single: assert property (speed_sample_strobe[0] && !speed_continuous[0] |=>
    !speed_sample_strobe[0] || speed_continuous[0])
    else $error("sample tick longer than one cycle");
  a_lock_hold: assert property (config_lock && $past(config_lock) |->
    $stable(speed_continuous) && $stable(pwm2_is_alert))
    else $error("locked config changed");
  a_event_pin: assert property (overheat_timer_event |-> !$past(overheat_pin_n))
    else $error("timer event without overheat");
endmodule : amotr_regs_monitor
bind amotr_regs amotr_regs_monitor u_monitor (.*);
`default_nettype wire

// file: amotr_host.sv
/*
  apb host model standing in for the serial host controller.
  assumes a one-cycle req from the bench; done pulses when rdata is valid.
*/
`timescale 1ns/1ps
`default_nettype none
module amotr_host (
  input wire logic mclk,
  input wire logic rst,
  input wire logic req,
  input wire logic wr,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic done,
  output logic [31:0] rdata
);
  logic owed; // read data lands one edge after the access
  // setup, access held until pready, then release
  always @(posedge mclk) begin
    done <= owed;
    owed <= 1'b0;
    if (owed) rdata <= prdata;
    if (rst) begin
      psel <= 1'b0;
      penable <= 1'b0;
    end else if (psel && penable && pready) begin
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr; // released lines must not look valid
      pwdata <= ~pwdata;
      owed <= 1'b1;
    end else if (psel) begin
      penable <= 1'b1;
    end else if (req) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
    end
  end
endmodule : amotr_host
`default_nettype wire

// file: amotr_regs_tb.sv
/*
  self-checking bench for the alert mask and overheat timer registers.
  assumes short step and sample counts set by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; $display("unexpected %s expected %h seen %h", n, e, a); end end
module amotr_regs_tb;
  import amotr_pkg::*;
  logic mclk = 1'b0, rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, pwm2_is_alert, fans_full_speed;
  logic overheat_timer_event, alert_pin_o, alert_pin_oe, done, seen_err = 1'b0;
  logic [11:0] paddr, addr = 12'h000;
  logic [31:0] pwdata, prdata, rdata, wdata = 32'h0;
  logic [9:0] volt_reading = '0, supply_reading = '0, remote_a_reading = '0;
  logic [9:0] local_reading = '0, remote_b_reading = '0;
  logic [7:0] volt_high, supply_high, remote_a_high, local_high, remote_b_high;
  logic [4:0] high_byte_read = '0, channel_limit = '0;
  logic [3:0] fan_fault = '0, speed_sample_strobe, speed_continuous;
  logic [1:0] diode_fault = '0;
  logic status2_limit_any = 1'b0, fourth_is_overheat = 1'b0, overheat_pin_n = 1'b1;
  logic config_lock = 1'b0, req = 1'b0, wr = 1'b0;
  int err_total = 0, check_count = 0, cyc = 0;
  // short counts keep the run brief
  amotr_regs #(.STEP_CYC(10), .SLOW_CYC(40), .FAST_CYC(10)) dut (.*);
  amotr_host u_host (.*);
  always #12.5 mclk = ~mclk;
  // timeout and sticky slave-error watch
  always @(posedge mclk) begin
    cyc++;
    if (psel && penable && pslverr) seen_err <= 1'b1;
    if (cyc > 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    wr <= w;
    addr <= {2'b00, idx, 2'b00};
    wdata <= d;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
  endtask : bus
  task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 32'h0);
    `CHK("register", exp, rdata[7:0])
  endtask : rchk
  task automatic t_regs();
    rchk(AMOTR_IDX_MASK_CH, AMOTR_RST_MASK);
    rchk(AMOTR_IDX_CFG3, AMOTR_RST_CFG3);
    rchk(AMOTR_IDX_OVH_STAT, AMOTR_RST_STAT);
    bus(1'b1, AMOTR_IDX_MASK_FLT, 32'hff);
    rchk(AMOTR_IDX_MASK_FLT, 8'hfd);
    bus(1'b1, AMOTR_IDX_OVH_STAT, 32'hff);
    rchk(AMOTR_IDX_OVH_STAT, 8'h00);
    rchk(8'hff, 8'h00);
    `CHK("slave error", 1'b1, seen_err)
  endtask : t_regs
  // each condition alone must pull alert low, then its mask bit silences it
  task automatic t_alert();
    int cb[12] = '{0, 2, 4, 5, 6, 7, 2, 3, 4, 5, 6, 7};
    logic [7:0] mi;
    bus(1'b1, AMOTR_IDX_CFG3, 32'h01);
    `CHK("pwm2 alert", 1'b1, pwm2_is_alert)
    bus(1'b1, AMOTR_IDX_MASK_CH, 32'h0);
    bus(1'b1, AMOTR_IDX_MASK_FLT, 32'h0);
    for (int i = 0; i < 12; i++) begin
      mi = (i < 6) ? AMOTR_IDX_MASK_CH : AMOTR_IDX_MASK_FLT;
      {diode_fault, fan_fault, status2_limit_any, channel_limit} <= 12'h1 << i;
      bus(1'b1, mi, 32'h0);
      `CHK("alert", 1'b1, alert_pin_oe)
      bus(1'b1, mi, 32'h1 << cb[i]);
      `CHK("masked alert", 1'b0, alert_pin_oe)
    end
    {diode_fault, fan_fault, status2_limit_any, channel_limit} <= 12'h0;
  endtask : t_alert
  task automatic t_overheat();
    fourth_is_overheat <= 1'b1;
    bus(1'b1, AMOTR_IDX_MASK_FLT, 32'h0);
    bus(1'b1, AMOTR_IDX_OVH_LIMIT, 32'h3);
    overheat_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("no full_speed_on_overheat", 1'b0, fans_full_speed)
    overheat_pin_n <= 1'b1;
    rchk(AMOTR_IDX_OVH_STAT, 8'h00);
    bus(1'b1, AMOTR_IDX_CFG3, 32'h07);
    overheat_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("full_speed_on_overheat", 1'b1, fans_full_speed)
    overheat_pin_n <= 1'b1;
    rchk(AMOTR_IDX_OVH_STAT, 8'h01);
    rchk(AMOTR_IDX_OVH_STAT, 8'h00);
    overheat_pin_n <= 1'b0;
    repeat (10) @(posedge mclk);
    bus(1'b0, AMOTR_IDX_OVH_STAT, 32'h0);
    `CHK("early upper bits", 7'h00, rdata[7:1])
    repeat (40) @(posedge mclk);
    bus(1'b0, AMOTR_IDX_OVH_STAT, 32'h0);
    `CHK("count range", 1'b1, rdata[7:0] >= 8'h04 && rdata[7:0] <= 8'h06)
    `CHK("event", 1'b1, overheat_timer_event)
    `CHK("event alert", 1'b1, alert_pin_oe)
    bus(1'b1, AMOTR_IDX_MASK_FLT, 32'h20);
    `CHK("event masked", 1'b0, alert_pin_oe)
    repeat (2700) @(posedge mclk);
    rchk(AMOTR_IDX_OVH_STAT, 8'hff);
    overheat_pin_n <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("event off", 1'b0, overheat_timer_event)
    fourth_is_overheat <= 1'b0;
  endtask : t_overheat
  // a low-bits read freezes the high bytes until those are read
  task automatic t_freeze();
    volt_reading <= 10'h1f1;
    supply_reading <= 10'h2a2;
    remote_a_reading <= 10'h001;
    local_reading <= 10'h002;
    remote_b_reading <= 10'h3ff;
    repeat (4) @(posedge mclk);
    rchk(AMOTR_IDX_VOLT_LOW, 8'h21);
    volt_reading <= 10'h000;
    repeat (4) @(posedge mclk);
    `CHK("frozen high", 8'h7c, volt_high)
    `CHK("supply high", 8'ha8, supply_high)
    `CHK("remote a high", 8'h00, remote_a_high)
    `CHK("local high", 8'h00, local_high)
    high_byte_read <= 5'h03;
    @(posedge mclk);
    high_byte_read <= 5'h00;
    repeat (4) @(posedge mclk);
    `CHK("released high", 8'h00, volt_high)
    rchk(AMOTR_IDX_TEMP_LOW, 8'he4);
    `CHK("temp high", 8'hff, remote_b_high)
  endtask : t_freeze
  task automatic t_config();
    int ns;
    int nf;
    ns = 0;
    nf = 0;
    bus(1'b1, AMOTR_IDX_CFG3, 32'h00);
    repeat (400) @(posedge mclk) ns += speed_sample_strobe[0];
    bus(1'b1, AMOTR_IDX_CFG3, 32'h08);
    repeat (400) @(posedge mclk) nf += speed_sample_strobe[0];
    `CHK("fast rate", 1'b1, ns > 0 && nf >= 3 * ns)
    bus(1'b1, AMOTR_IDX_CFG3, 32'hf1);
    `CHK("continuous", 4'hf, speed_continuous)
    config_lock <= 1'b1;
    bus(1'b1, AMOTR_IDX_CFG3, 32'h00);
    rchk(AMOTR_IDX_CFG3, 8'hf1);
    config_lock <= 1'b0;
  endtask : t_config
  task automatic end_of_test();
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_alert();
    t_overheat();
    t_freeze();
    t_config();
    end_of_test();
  end
endmodule : amotr_regs_tb
`default_nettype wire
